// >>> verilog/idt_defines.vh
`ifndef IDT_DEFINES_VH
`define IDT_DEFINES_VH

// decoder states
`define IDT_ST_IDLE      3'h0
`define IDT_ST_MODRM     3'h1
`define IDT_ST_IMM_LO    3'h2
`define IDT_ST_IMM_HI    3'h3
`define IDT_ST_SECOND    3'h4
`define IDT_ST_EXEC      3'h5
`define IDT_ST_STRING    3'h6

// opcode patterns and masks
`define IDT_OP_COPY_TO_REG  8'h8A
`define IDT_MK_W            8'hFE
`define IDT_OP_SEG_LOAD     8'h8E
`define IDT_OP_IMM_REG      8'hB0
`define IDT_MK_IMM_REG      8'hF0
`define IDT_OP_IMM_RM       8'hC6
`define IDT_OP_POP_SEG      8'h07
`define IDT_MK_POP_SEG      8'hE7
`define IDT_OP_FAR_EXTRA    8'hC4
`define IDT_OP_FLAGS_AH     8'h9E
`define IDT_OP_GROUP3       8'hF6
`define IDT_OP_SIGNED_IMM   8'h69
`define IDT_MK_SIGNED_IMM   8'hFD
`define IDT_OP_BCD_ADJ      8'hD4
`define IDT_OP_BCD_BASE     8'h0A
`define IDT_OP_WIDEN        8'h98
`define IDT_OP_SHIFT_ONE    8'hD0
`define IDT_OP_SHIFT_CNT    8'hD2
`define IDT_OP_TEST_RM      8'h84
`define IDT_OP_STR_COPY     8'hA4
`define IDT_OP_STR_CMP      8'hA6
`define IDT_OP_STR_IN       8'h6C
`define IDT_OP_REP          8'hF3
`define IDT_OP_REP_Z        8'hF2
`define IDT_MK_REP          8'hFE
`define IDT_OP_GROUP5       8'hFF
`define IDT_OP_FAR_CALL     8'h9A

// field positions
`define IDT_BIT_W        0
`define IDT_BIT_D        1
`define IDT_BIT_S        1
`define IDT_BIT_IMM_W    3
`define IDT_MOD_REG      2'h3
`define IDT_SEG_CODE     2'h1
`define IDT_REG_MUL      3'h4
`define IDT_REG_DIV      3'h6
`define IDT_REG_SIGNED_QUOTIENT     3'h7
`define IDT_REG_FARCALL  3'h3

// base clock counts
`define IDT_CLK_2        8'h02
`define IDT_CLK_3        8'h03
`define IDT_CLK_4        8'h04
`define IDT_CLK_5        8'h05
`define IDT_CLK_6        8'h06
`define IDT_CLK_7        8'h07
`define IDT_CLK_8        8'h08
`define IDT_CLK_9        8'h09
`define IDT_CLK_13       8'h0D
`define IDT_CLK_14       8'h0E
`define IDT_CLK_16       8'h10
`define IDT_CLK_17       8'h11
`define IDT_CLK_19       8'h13
`define IDT_CLK_20       8'h14
`define IDT_CLK_21       8'h15
`define IDT_CLK_22       8'h16
`define IDT_CLK_24       8'h18
`define IDT_CLK_25       8'h19
`define IDT_CLK_28       8'h1C
`define IDT_CLK_29       8'h1D
`define IDT_CLK_41       8'h29
`define IDT_CLK_82       8'h52
`define IDT_CLK_86       8'h56
`define IDT_CLK_ZERO     8'h00

// call gate kinds on gate_kind_i
`define IDT_GATE_NONE    2'h0
`define IDT_GATE_SAME    2'h1
`define IDT_GATE_INNER   2'h2

// phase value on which each processor clock ends
`define IDT_SYS_PER_PCLK 1'b1

`endif

// >>> verilog/idt_clock_counter.v
`timescale 1ns/100ps
// counts processor clocks (one per two system clocks) down to zero
module idt_clock_counter (
  input  wire        core_clk_i,  // system clock
  input  wire        reset_i,     // synchronous, active high
  input  wire        load_i,      // load a new count
  input  wire [15:0] count_i,     // processor clocks to run
  output wire        busy_o,      // count still running
  output wire        done_o       // last processor clock finishing
);
`include "idt_defines.vh"

  reg [15:0] remain;  // processor clocks left
  reg        phase;   // system clock half of processor clock

  // divide by two: step the count once per processor clock
  always @(posedge core_clk_i) begin
    if (reset_i) begin
      remain <= 16'h0000;
      phase  <= 1'b0;
    end else if (load_i) begin
      remain <= count_i;
      phase  <= 1'b0;
    end else if (remain != 16'h0000) begin
      phase <= ~phase;
      if (phase == `IDT_SYS_PER_PCLK)
        remain <= remain - 16'h0001;
    end
  end

  assign busy_o = (remain != 16'h0000);
  assign done_o = (remain == 16'h0001) && (phase == `IDT_SYS_PER_PCLK);

endmodule // idt_clock_counter

// >>> verilog/idt_decoder.v
`timescale 1ns/100ps
// instruction decoder and clock-count sequencer
module idt_decoder (
  input  wire        core_clk_i,       // system clock, 100 MHz
  input  wire        reset_i,          // synchronous, active high
  input  wire [7:0]  byte_i,           // next instruction byte
  input  wire        byte_valid_i,     // byte_i holds a byte
  input  wire        protected_i,      // protected virtual mode
  input  wire [15:0] count_register_i, // string repeat count
  input  wire [7:0]  shift_count_byte_i, // shift count
  input  wire [1:0]  gate_kind_i,      // far call gate kind
  input  wire [4:0]  gate_params_i,    // gate parameter count x
  input  wire [3:0]  next_code_bytes_i, // m: bytes of next instr
  input  wire [7:0]  penalty_i,        // wait and address penalty
  input  wire        divide_fault_i,   // divide operand fault
  output wire        byte_ready_o,     // byte accepted this cycle
  output reg  [7:0]  opcode_o,         // decoded opcode
  output reg  [7:0]  modrm_o,          // decoded ModRM byte
  output reg  [15:0] immediate_o,      // immediate, extended
  output reg         word_op_o,        // word sized operation
  output reg         to_reg_o,         // result to reg field
  output reg         mem_operand_o,    // operand in memory
  output reg         flags_only_o,     // result discarded
  output reg  [15:0] clocks_o,         // processor clocks charged
  output reg         busy_o,           // executing
  output reg         done_o,           // execution complete pulse
  output reg         undefined_o,      // undefined opcode pulse
  output reg         divide_error_o    // divide exception pulse
);
`include "idt_defines.vh"

  reg [2:0]  state;      // decoder state
  reg [7:0]  op;         // first opcode byte
  reg [7:0]  rm;         // ModRM byte
  reg [7:0]  prefix;     // last repeat prefix seen, zero after reset
  reg        has_prefix; // repeat prefix seen
  reg        need_imm;   // ModRM instruction carries immediate
  reg        imm_word;   // immediate has two bytes
  reg        imm_sext;   // byte immediate sign-extended
  reg        is_div;     // divide instruction pending
  reg [15:0] base;       // charged count
  reg        cnt_load;   // start the counter
  reg [2:0]  next_state; // next decoder state

  wire       cnt_busy;   // counter running
  wire       cnt_done;   // counter finishing
  wire       cnt_start;  // load, unless the encoding is refused
  wire [2:0] rm_reg  = modrm_field(byte_i);
  wire       rm_mem  = (byte_i[7:6] != `IDT_MOD_REG);
  wire       wbit    = op[`IDT_BIT_W];

  // middle field of a ModRM byte
  function [2:0] modrm_field;
    input [7:0] b;
    begin
      modrm_field = b[5:3];
    end
  endfunction

  // opcodes that need a ModRM byte
  function needs_modrm;
    input [7:0] o;
    begin
      needs_modrm =
        ((o & `IDT_MK_W) == `IDT_OP_COPY_TO_REG) ||
        (o == `IDT_OP_SEG_LOAD) ||
        ((o & `IDT_MK_W) == `IDT_OP_IMM_RM) ||
        (o == `IDT_OP_FAR_EXTRA) ||
        ((o & `IDT_MK_W) == `IDT_OP_GROUP3) ||
        ((o & `IDT_MK_SIGNED_IMM) == `IDT_OP_SIGNED_IMM) ||
        ((o & `IDT_MK_W) == `IDT_OP_SHIFT_ONE) ||
        ((o & `IDT_MK_W) == `IDT_OP_SHIFT_CNT) ||
        ((o & `IDT_MK_W) == `IDT_OP_TEST_RM) ||
        (o == `IDT_OP_GROUP5);
    end
  endfunction

  // counter shared by every instruction
  idt_clock_counter u_counter (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .load_i     (cnt_start),
    .count_i    (base),
    .busy_o     (cnt_busy),
    .done_o     (cnt_done)
  );

  // bytes are only taken while decoding, not executing
  assign byte_ready_o = byte_valid_i && (state != `IDT_ST_EXEC) &&
                        (state != `IDT_ST_STRING);

  // count for one complete ModRM instruction, per opcode and operand
  function [15:0] rm_count;
    input [7:0] o;
    input [7:0] r;
    input       mem;
    input       prot;
    input       w;
    reg   [7:0] c;
    begin
      c = `IDT_CLK_ZERO;
      if ((o & `IDT_MK_W) == `IDT_OP_COPY_TO_REG)
        c = mem ? `IDT_CLK_5 : `IDT_CLK_2;
      else if (o == `IDT_OP_SEG_LOAD)
        c = prot ? (mem ? `IDT_CLK_19 : `IDT_CLK_17)
                 : (mem ? `IDT_CLK_5 : `IDT_CLK_2);
      else if ((o & `IDT_MK_W) == `IDT_OP_IMM_RM)
        c = mem ? `IDT_CLK_3 : `IDT_CLK_2;
      else if (o == `IDT_OP_FAR_EXTRA)
        c = prot ? `IDT_CLK_21 : `IDT_CLK_7;
      else if ((o & `IDT_MK_SIGNED_IMM) == `IDT_OP_SIGNED_IMM)
        c = mem ? `IDT_CLK_24 : `IDT_CLK_21;
      else if ((o & `IDT_MK_W) == `IDT_OP_SHIFT_ONE)
        c = mem ? `IDT_CLK_7 : `IDT_CLK_2;
      else if ((o & `IDT_MK_W) == `IDT_OP_SHIFT_CNT)
        c = mem ? `IDT_CLK_8 : `IDT_CLK_5;
      else if ((o & `IDT_MK_W) == `IDT_OP_TEST_RM)
        c = mem ? `IDT_CLK_6 : `IDT_CLK_2;
      else if ((o & `IDT_MK_W) == `IDT_OP_GROUP3) begin
        case (r[5:3])
          `IDT_REG_MUL:
            c = w ? `IDT_CLK_21 : `IDT_CLK_13;
          `IDT_REG_DIV:
            c = w ? `IDT_CLK_22 : `IDT_CLK_14;
          `IDT_REG_SIGNED_QUOTIENT:
            c = w ? `IDT_CLK_25 : `IDT_CLK_17;
          default:
            c = `IDT_CLK_ZERO;
        endcase
        // memory operand adds three to every product and quotient
        if (mem)
          c = c + `IDT_CLK_3;
      end
      rm_count = {8'h00, c};
    end
  endfunction

  // string count: single, or base plus cost per iteration
  function [15:0] str_count;
    input [7:0]  o;
    input        rep;
    input [15:0] n;
    begin
      if (!rep)
        str_count = {8'h00, `IDT_CLK_5};
      else if ((o & `IDT_MK_W) == `IDT_OP_STR_CMP)
        str_count = {8'h00, `IDT_CLK_5} +
                    n * {8'h00, `IDT_CLK_9};
      else
        str_count = {8'h00, `IDT_CLK_5} +
                    (n << 2);
    end
  endfunction

  // next-state and count selection
  always @* begin
    next_state = state;
    cnt_load   = 1'b0;
    base       = 16'h0000;
    case (state)
      `IDT_ST_IDLE: begin
        if (byte_valid_i && !cnt_busy) begin
          if ((byte_i & `IDT_MK_REP) == `IDT_OP_REP_Z)
            next_state = `IDT_ST_IDLE;                       // prefix byte
          else if (needs_modrm(byte_i))
            next_state = `IDT_ST_MODRM;
          else if (byte_i == `IDT_OP_BCD_ADJ ||
                   byte_i == `IDT_OP_FAR_CALL)
            next_state = `IDT_ST_SECOND;
          else if ((byte_i & `IDT_MK_IMM_REG) == `IDT_OP_IMM_REG)
            next_state = `IDT_ST_IMM_LO;
          else if ((byte_i & `IDT_MK_W) == `IDT_OP_STR_COPY ||
                   ((byte_i & `IDT_MK_W) == `IDT_OP_STR_CMP &&
                    has_prefix) ||
                   (byte_i & `IDT_MK_W) == `IDT_OP_STR_IN) begin
            next_state = `IDT_ST_STRING;
            cnt_load   = 1'b1;
            base       = str_count(byte_i, has_prefix,
                                   count_register_i);
          end else if (byte_i == `IDT_OP_FLAGS_AH ||
                       byte_i == `IDT_OP_WIDEN) begin
            next_state = `IDT_ST_EXEC;
            cnt_load   = 1'b1;
            base       = {8'h00, `IDT_CLK_2};
          end else if ((byte_i & `IDT_MK_POP_SEG) == `IDT_OP_POP_SEG &&
                       byte_i[4:3] != `IDT_SEG_CODE) begin
            next_state = `IDT_ST_EXEC;
            cnt_load   = 1'b1;
            base       = {8'h00, protected_i ? `IDT_CLK_20
                                             : `IDT_CLK_5};
          end
        end
      end
      `IDT_ST_MODRM: begin
        if (byte_valid_i) begin
          if (need_imm)
            next_state = `IDT_ST_IMM_LO;
          else begin
            next_state = `IDT_ST_EXEC;
            cnt_load   = 1'b1;
            if (op == `IDT_OP_GROUP5)
              base = (protected_i ? {8'h00, `IDT_CLK_29}
                                  : {8'h00, `IDT_CLK_16}) +
                     {12'h000, next_code_bytes_i};
            else
              base = rm_count(op, byte_i, rm_mem, protected_i, wbit);
            if ((op & `IDT_MK_W) == `IDT_OP_SHIFT_CNT)
              base = base + {8'h00, shift_count_byte_i};
          end
        end
      end
      `IDT_ST_IMM_LO: begin
        if (byte_valid_i) begin
          if (imm_word)
            next_state = `IDT_ST_IMM_HI;
          else begin
            next_state = `IDT_ST_EXEC;
            cnt_load   = 1'b1;
            base       = ((op & `IDT_MK_IMM_REG) == `IDT_OP_IMM_REG)
                         ? {8'h00, `IDT_CLK_2}
                         : rm_count(op, rm, mem_operand_o,
                                    protected_i, wbit);
          end
        end
      end
      `IDT_ST_IMM_HI: begin
        if (byte_valid_i) begin
          next_state = `IDT_ST_EXEC;
          cnt_load   = 1'b1;
          base       = ((op & `IDT_MK_IMM_REG) == `IDT_OP_IMM_REG)
                       ? {8'h00, `IDT_CLK_2}
                       : rm_count(op, rm, mem_operand_o,
                                  protected_i, wbit);
        end
      end
      `IDT_ST_SECOND: begin
        if (byte_valid_i) begin
          next_state = `IDT_ST_EXEC;
          cnt_load   = 1'b1;
          if (op == `IDT_OP_BCD_ADJ)
            base = {8'h00, `IDT_CLK_16};
          else if (gate_kind_i == `IDT_GATE_INNER)
            base = ((gate_params_i == 5'h00) ? {8'h00, `IDT_CLK_82}
                   : {8'h00, `IDT_CLK_86} +
                     {9'h000, gate_params_i, 2'b00}) +
                   {12'h000, next_code_bytes_i};
          else
            base = {8'h00, `IDT_CLK_41} +
                   {12'h000, next_code_bytes_i};
        end
      end
      `IDT_ST_EXEC,
      `IDT_ST_STRING: begin
        if (cnt_done)
          next_state = `IDT_ST_IDLE;
      end
      default:
        next_state = `IDT_ST_IDLE;
    endcase
    // bus waits and address penalties ride on every base count
    if (cnt_load)
      base = base + {8'h00, penalty_i};
  end

  // legality: anything not decoded, or register form of memory-only
  wire idle_bad = (state == `IDT_ST_IDLE) && byte_valid_i &&
                  !cnt_busy && (next_state == `IDT_ST_IDLE) &&
                  ((byte_i & `IDT_MK_REP) != `IDT_OP_REP_Z);
  wire rm_bad = (state == `IDT_ST_MODRM) && byte_valid_i && (
                  ((op == `IDT_OP_FAR_EXTRA) && !rm_mem) ||
                  ((op == `IDT_OP_GROUP5) &&
                   (rm_reg != `IDT_REG_FARCALL || !rm_mem)) ||
                  (((op & `IDT_MK_W) == `IDT_OP_GROUP3) &&
                   rm_reg != `IDT_REG_MUL && rm_reg != `IDT_REG_DIV &&
                   rm_reg != `IDT_REG_SIGNED_QUOTIENT));
  wire sec_bad = (state == `IDT_ST_SECOND) && byte_valid_i &&
                 (op == `IDT_OP_BCD_ADJ) &&
                 (byte_i != `IDT_OP_BCD_BASE);

  // a refused encoding must not start the counter, or a stray done follows
  assign cnt_start = cnt_load && !rm_bad && !sec_bad;

  // state, fields and outputs
  always @(posedge core_clk_i) begin
    if (reset_i) begin
      state          <= `IDT_ST_IDLE;
      op             <= 8'h00;
      rm             <= 8'h00;
      prefix         <= 8'h00;
      has_prefix     <= 1'b0;
      need_imm       <= 1'b0;
      imm_word       <= 1'b0;
      imm_sext       <= 1'b0;
      is_div         <= 1'b0;
      opcode_o       <= 8'h00;
      modrm_o        <= 8'h00;
      immediate_o    <= 16'h0000;
      word_op_o      <= 1'b0;
      to_reg_o       <= 1'b0;
      mem_operand_o  <= 1'b0;
      flags_only_o   <= 1'b0;
      clocks_o       <= 16'h0000;
      busy_o         <= 1'b0;
      done_o         <= 1'b0;
      undefined_o    <= 1'b0;
      divide_error_o <= 1'b0;
    end else begin
      done_o         <= cnt_done;
      busy_o         <= !rm_bad && !sec_bad &&
                        ((next_state == `IDT_ST_EXEC) ||
                         (next_state == `IDT_ST_STRING));
      // a bad encoding drops back to idle and flags it once
      undefined_o    <= idle_bad || rm_bad || sec_bad;
      // divide fault only reported as a divide finishes
      divide_error_o <= cnt_done && is_div && divide_fault_i;
      state          <= (rm_bad || sec_bad) ? `IDT_ST_IDLE : next_state;
      if (cnt_start)
        clocks_o <= base;
      if (cnt_done)
        has_prefix <= 1'b0;
      if (state == `IDT_ST_IDLE && byte_valid_i && !cnt_busy) begin
        if ((byte_i & `IDT_MK_REP) == `IDT_OP_REP_Z) begin
          prefix     <= byte_i;
          has_prefix <= 1'b1;
        end else begin
          op           <= byte_i;
          opcode_o     <= byte_i;
          word_op_o    <= byte_i[`IDT_BIT_W];
          to_reg_o     <= byte_i[`IDT_BIT_D];
          flags_only_o <= ((byte_i & `IDT_MK_W) == `IDT_OP_TEST_RM);
          immediate_o  <= 16'h0000;
          is_div       <= 1'b0;
          mem_operand_o <= 1'b0;
          // immediate-to-register keeps width in bit three
          if ((byte_i & `IDT_MK_IMM_REG) == `IDT_OP_IMM_REG) begin
            word_op_o <= byte_i[`IDT_BIT_IMM_W];
            imm_word  <= byte_i[`IDT_BIT_IMM_W];
            imm_sext  <= 1'b0;
          end else if ((byte_i & `IDT_MK_SIGNED_IMM) ==
                       `IDT_OP_SIGNED_IMM) begin
            imm_word  <= ~byte_i[`IDT_BIT_S];
            imm_sext  <= byte_i[`IDT_BIT_S];
          end else begin
            imm_word  <= byte_i[`IDT_BIT_W];
            imm_sext  <= 1'b0;
          end
          need_imm <= ((byte_i & `IDT_MK_W) == `IDT_OP_IMM_RM) ||
                      ((byte_i & `IDT_MK_SIGNED_IMM) ==
                       `IDT_OP_SIGNED_IMM);
        end
      end
      if (state == `IDT_ST_MODRM && byte_valid_i) begin
        rm            <= byte_i;
        modrm_o       <= byte_i;
        mem_operand_o <= rm_mem;
        is_div <= ((op & `IDT_MK_W) == `IDT_OP_GROUP3) &&
                  (rm_reg == `IDT_REG_DIV || rm_reg == `IDT_REG_SIGNED_QUOTIENT);
      end
      if (state == `IDT_ST_IMM_LO && byte_valid_i)
        immediate_o <= imm_sext ? {{8{byte_i[7]}}, byte_i}
                                : {8'h00, byte_i};
      if (state == `IDT_ST_IMM_HI && byte_valid_i)
        immediate_o <= {byte_i, immediate_o[7:0]};
      if (state == `IDT_ST_SECOND && byte_valid_i)
        modrm_o <= byte_i;
    end
  end

endmodule // idt_decoder

// >>> verification/idt_decoder_assertions.sv
`timescale 1ns/100ps
// decoder port checker; lengths are in system clocks
module idt_decoder_checker (
  input wire logic        core_clk_i,
  input wire logic        reset_i,
  input wire logic [7:0]  byte_i,
  input wire logic        byte_valid_i,
  input wire logic [7:0]  penalty_i,
  input wire logic        byte_ready_o,
  input wire logic [15:0] clocks_o,
  input wire logic        busy_o,
  input wire logic        done_o,
  input wire logic        undefined_o,
  input wire logic        divide_error_o
);
  logic [16:0] run;  // cycles since busy rose
  // two system clocks per processor clock, so done lands at 2n
  always @(posedge core_clk_i) begin
    if (reset_i || !busy_o)
      run <= 17'h00000;
    else
      run <= run + 17'h00001;
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  // opcode taken right after the previous instruction ended
  sequence s_op(op);
    done_o ##1 (byte_ready_o && byte_i == op);
  endsequence
  AST_TAKE: assert property (
    byte_ready_o |-> byte_valid_i && !busy_o) else $error("bad take");
  AST_COUNT: assert property (
    done_o |-> run == {clocks_o, 1'b0})
    else $error("bad length");
  AST_END: assert property (
    done_o |-> !busy_o ##1 !done_o) else $error("done not a pulse");
  AST_HOLD: assert property (
    busy_o && $past(busy_o) |-> $stable(clocks_o)) else $error("moved");
  AST_FLAGS_AH: assert property (
    s_op(8'h9E) |=> busy_o && clocks_o == 16'h0002 + penalty_i)
    else $error("flags op count");
  AST_WIDEN: assert property (
    s_op(8'h98) |=> busy_o && clocks_o == 16'h0002 + penalty_i)
    else $error("widen op count");
  AST_UNDEF: assert property (
    undefined_o |=> !undefined_o && !busy_o) else $error("undef pulse");
  AST_DIV_ERR: assert property (
    divide_error_o |-> done_o) else $error("divide error off done");
endmodule // idt_decoder_checker

bind idt_decoder idt_decoder_checker u_chk (.core_clk_i(core_clk_i),
  .reset_i(reset_i), .byte_i(byte_i), .byte_valid_i(byte_valid_i),
  .penalty_i(penalty_i), .byte_ready_o(byte_ready_o),
  .clocks_o(clocks_o), .busy_o(busy_o), .done_o(done_o),
  .undefined_o(undefined_o), .divide_error_o(divide_error_o));

// >>> verification/idt_prefetch_model.sv
`timescale 1ns/100ps
// prefetch queue: offers bytes in order, holds each until taken
module idt_prefetch_model (
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic       ready_i,  // byte taken
  input  wire logic       gap_i,    // slow: idle cycle after each byte
  output logic      [7:0] byte_o,
  output logic            valid_o
);
  logic [7:0] q[$];  // bytes still to offer
  task automatic push(input logic [7:0] b);
    q.push_back(b);
  endtask
  // idle data toggles so a stale byte never looks fresh
  always @(posedge clk_i) begin
    if (reset_i) begin
      valid_o <= 1'b0;
      byte_o <= 8'hA5;
    end else if (valid_o && !ready_i) begin
      valid_o <= 1'b1;
    end else if (q.size() != 0 && !(valid_o && gap_i)) begin
      byte_o <= q.pop_front();
      valid_o <= 1'b1;
    end else begin
      valid_o <= 1'b0;
      byte_o <= ~byte_o;
    end
  end
endmodule // idt_prefetch_model

// >>> verification/testbench.sv
`timescale 1ns/100ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin err_count++; \
  $display("FAIL t=%0t got %0h want %0h", $time, a, e); end end
module testbench;
  typedef struct packed {
    logic [31:0] b; logic [2:0] n; logic p; logic [7:0] c;
    logic [1:0] g; logic [7:0] k; logic u;
  } idt_row_t;  // bytes, count, mode, n/x/m, gate, clocks, undefined
  logic core_clk_i = 1'b0, reset_i = 1'b1, protected_i = 1'b0;
  logic divide_fault_i = 1'b0, gap = 1'b0;
  logic [7:0] c = 8'h00, penalty_i = 8'h00;
  logic [1:0] gate_kind_i = 2'h0;
  wire [15:0] count_register_i = {8'h00, c};
  wire [7:0] shift_count_byte_i = c, byte_i;
  wire [4:0] gate_params_i = c[4:0];
  wire [3:0] next_code_bytes_i = c[3:0];
  wire [15:0] immediate_o, clocks_o;
  wire [7:0] opcode_o, modrm_o;
  wire byte_valid_i, byte_ready_o, word_op_o, to_reg_o, mem_operand_o;
  wire flags_only_o, busy_o, done_o, undefined_o, divide_error_o;
  int err_count = 0, n_tests = 0, cyc;
  bit und;
  idt_row_t rows[$] = '{
    '{32'h9E,1,0,0,0,2,0}, '{32'h98,1,0,0,0,2,0},
    '{32'h8AC0,2,0,0,0,2,0}, '{32'h8A04,2,1,0,0,5,0},
    '{32'h8E1C,2,0,0,0,5,0}, '{32'h8ED8,2,1,0,0,17,0},
    '{32'h8E1C,2,1,0,0,19,0}, '{32'hB012,2,0,0,0,2,0},
    '{32'hC6C012,3,0,0,0,2,0}, '{32'hC7C03412,4,0,0,0,2,0},
    '{32'h1F,1,0,0,0,5,0}, '{32'h1F,1,1,0,0,20,0}, '{32'h0F,1,0,0,0,0,1},
    '{32'hC404,2,1,0,0,21,0}, '{32'hC4C0,2,1,0,0,0,1},
    '{32'hF6E0,2,0,0,0,13,0}, '{32'hF7E0,2,0,0,0,21,0},
    '{32'hF624,2,0,0,0,16,0}, '{32'h6BC005,3,0,0,0,21,0},
    '{32'h69043412,4,0,0,0,24,0}, '{32'hD40A,2,0,0,0,16,0},
    '{32'hF6F0,2,0,0,0,14,0}, '{32'hF7F0,2,0,0,0,22,0},
    '{32'hF6F8,2,0,0,0,17,0}, '{32'hF7F8,2,0,0,0,25,0},
    '{32'hF63C,2,0,0,0,20,0}, '{32'hF73C,2,0,0,0,28,0},
    '{32'hD0E0,2,0,0,0,2,0}, '{32'hD024,2,0,0,0,7,0},
    '{32'hD2E0,2,0,3,0,8,0}, '{32'hD224,2,0,3,0,11,0},
    '{32'h84C0,2,0,0,0,2,0}, '{32'h8404,2,0,0,0,6,0},
    '{32'hA4,1,0,0,0,5,0}, '{32'h6C,1,0,0,0,5,0},
    '{32'hF3A4,2,0,3,0,17,0}, '{32'hF36C,2,0,2,0,13,0},
    '{32'hF2A6,2,0,2,0,23,0}, '{32'hFF1C,2,0,3,0,19,0},
    '{32'hFF1C,2,1,3,0,32,0}, '{32'hFFD8,2,0,0,0,0,1},
    '{32'h9A00,2,1,3,1,44,0},
    '{32'h9A00,2,1,3,2,101,0}, '{32'h9A00,2,1,0,2,82,0}};
  idt_prefetch_model PFQ (.clk_i(core_clk_i), .reset_i(reset_i),
    .ready_i(byte_ready_o), .gap_i(gap), .byte_o(byte_i),
    .valid_o(byte_valid_i));
  idt_decoder DUT (.core_clk_i(core_clk_i), .reset_i(reset_i),
    .byte_i(byte_i), .byte_valid_i(byte_valid_i),
    .protected_i(protected_i), .count_register_i(count_register_i),
    .shift_count_byte_i(shift_count_byte_i),
    .gate_kind_i(gate_kind_i), .gate_params_i(gate_params_i),
    .next_code_bytes_i(next_code_bytes_i), .penalty_i(penalty_i),
    .divide_fault_i(divide_fault_i), .byte_ready_o(byte_ready_o),
    .opcode_o(opcode_o), .modrm_o(modrm_o), .immediate_o(immediate_o),
    .word_op_o(word_op_o), .to_reg_o(to_reg_o),
    .mem_operand_o(mem_operand_o), .flags_only_o(flags_only_o),
    .clocks_o(clocks_o), .busy_o(busy_o), .done_o(done_o),
    .undefined_o(undefined_o), .divide_error_o(divide_error_o));
  initial forever #5 core_clk_i = ~core_clk_i;
  // queue bytes just after an edge, then wait for start or refusal
  task automatic run(input logic [31:0] b, input int n);
    @(posedge core_clk_i);
    #1;
    for (int i = 0; i < n; i++) PFQ.push(b[8*(n-1-i) +: 8]);
    cyc = 0;
    while (busy_o !== 1'b1 && undefined_o !== 1'b1 && cyc < 100) begin
      @(posedge core_clk_i);
      #1;
      cyc++;
    end
    und = (undefined_o === 1'b1);
  endtask
  // charged count, then done exactly two system clocks per count
  task automatic fin(input logic [7:0] k);
    `CHK(clocks_o, {8'h00, k})
    cyc = 0;
    while (done_o !== 1'b1 && cyc < 700) begin
      @(posedge core_clk_i);
      #1;
      cyc++;
    end
    `CHK(cyc, 2 * k)
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge core_clk_i);
    reset_i <= 1'b0;
    foreach (rows[i]) begin
      @(posedge core_clk_i);
      protected_i <= rows[i].p;
      c <= rows[i].c;
      gate_kind_i <= rows[i].g;
      run(rows[i].b, rows[i].n);
      `CHK(und, rows[i].u)
      if (!rows[i].u) fin(rows[i].k);
      $display("row %0d done", i);
    end
    gap <= 1'b1;  // slow queue: word immediate, low byte first
    run(32'hB83412, 3);
    `CHK({immediate_o, word_op_o}, 17'h02469)
    fin(8'h02);
    gap <= 1'b0;
    run(32'h6BC0FF, 3);
    `CHK(immediate_o, 16'hFFFF)
    fin(8'h15);
    run(32'h8A04, 2);
    `CHK({to_reg_o, mem_operand_o}, 2'b11)
    `CHK({opcode_o, modrm_o}, 16'h8A04)
    fin(8'h05);
    run(32'h84C0, 2);
    `CHK({flags_only_o, word_op_o}, 2'b10)
    fin(8'h02);
    divide_fault_i <= 1'b1;
    run(32'hF7F0, 2);
    fin(8'h16);
    `CHK(divide_error_o, 1'b1)
    divide_fault_i <= 1'b0;
    $display("field test done");
    // three opcodes queued at once: later ones wait out the first
    run(32'h989E98, 3);
    fin(8'h02);
    repeat (2) begin
      run(32'h0, 0);
      fin(8'h02);
    end
    penalty_i <= 8'h03;
    run(32'h9E, 1);
    fin(8'h05);
    penalty_i <= 8'h00;
    $display("queue test done");
    // reset in mid-instruction clears everything
    run(32'hF7F8, 2);
    repeat (5) @(posedge core_clk_i);
    reset_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    reset_i <= 1'b0;
    @(posedge core_clk_i);
    #1;
    `CHK({busy_o, done_o, clocks_o}, 18'h00000)
    run(32'h9E, 1);
    fin(8'h02);
    $display("reset test done");
    report_and_stop();
  end
  // whole run needs about 2000 cycles
  initial begin
    #400000;
    err_count++;
    $display("FAIL t=%0t watchdog", $time);
    report_and_stop();
  end
endmodule // testbench
